// ==== logic/frame_format_classifier.sv ====
// Frame-format classifier with clear-header layout and pause buffer
//
// Overview of operation
// - Each association chooses its own set of fields used for its match.
// - Before decryption, everything after the SecTAG counts as encrypted.
// - Standard transmit matches addresses, present tags and VIDs, Ethertype.
// - Standard receive matches addresses and SecTAG only, any tag count.
// - One-tag bypass keeps the tag clear; receive may match TPID, VID.
// - Dual-tagged frame with one-tag bypass exposes only the outer tag on receive.
// - Two-tag bypass keeps both tags clear; receive may match both.
// - One-label MPLS keeps addresses, MPLS type, label clear both ways.
// - Two-label MPLS transmit may match addresses, type and both labels.
// - Keys of 128 or 256 bits, chosen per association context.
// - Tags or labels go out clear while the inner payload is protected.
// - Block sits between system-side MAC and line-side MAC, transparent.
// - Egress growth triggers pause frames; system MAC must stop sending.
// - A buffer holds egress beats during growth and decides on pause.
// - Bypassed tags are outside both encryption and authentication.
// - A bypassed MPLS header is outside encryption and authentication.
// - Confidentiality offsets of 0 to 127 bytes, byte granular, accepted.
`timescale 1ns/1ps
module frame_format_classifier
  import frame_class_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Per-association context and observed frame
  input wire sa_ctx_t ctx,
  input wire logic [1:0] tag_count,
  input wire logic mpls_seen,
  input wire logic ctx_valid,
  // Classification answer
  output class_result_t result,
  output logic result_valid,
  // System-side egress beats
  input wire logic sys_valid,
  output logic sys_ready,
  input wire beat_t sys_beat,
  // Line-side egress beats
  output logic line_valid,
  input wire logic line_ready,
  output beat_t line_beat,
  // Pause request toward the system MAC
  output logic pause_req,
  output logic [15:0] pause_quanta
);

  // Classification layout
  field_set_t usable;
  logic [5:0] clear_len;
  logic [7:0] enc_start;
  logic [4:0] key_bytes;
  logic ofs_ok, tag_ok;
  class_result_t next_result;
  logic next_result_valid;

  always_comb begin
    usable = '0;
    clear_len = 6'(ADDR_BYTES);
    tag_ok = 1'b1;
    // Addresses are always in clear in both directions
    usable.dest_addr = 1'b1;
    usable.src_addr = 1'b1;
    unique case (ctx.fmt)
      FMT_STANDARD: begin
        if (!ctx.rx_dir) begin
          // Transmit sees the plaintext header
          usable.tpid_outer = (tag_count != 2'h0);
          usable.vid_outer = (tag_count != 2'h0);
          usable.tpid_inner = (tag_count == 2'h2);
          usable.vid_inner = (tag_count == 2'h2);
          usable.etype = 1'b1;
        end else begin
          // All tags hidden behind the SecTAG
          usable.sectag = 1'b1;
        end
      end
      FMT_ONE_TAG_BYPASS: begin
        tag_ok = (tag_count != 2'h0);
        // Only the outer tag stays clear
        clear_len = 6'(ADDR_BYTES + TAG_BYTES);
        usable.tpid_outer = 1'b1;
        usable.vid_outer = 1'b1;
        if (!ctx.rx_dir) begin
          usable.tpid_inner = (tag_count == 2'h2);
          usable.vid_inner = (tag_count == 2'h2);
          usable.etype = 1'b1;
        end else begin
          usable.sectag = 1'b1;
        end
      end
      FMT_TWO_TAG_BYPASS: begin
        tag_ok = (tag_count == 2'h2);
        clear_len = 6'(ADDR_BYTES + 2 * TAG_BYTES);
        usable.tpid_outer = 1'b1;
        usable.vid_outer = 1'b1;
        usable.tpid_inner = 1'b1;
        usable.vid_inner = 1'b1;
        usable.etype = !ctx.rx_dir;
        usable.sectag = ctx.rx_dir;
      end
      FMT_MPLS_ONE: begin
        tag_ok = mpls_seen;
        // MPLS type and label clear in both directions
        clear_len = 6'(ADDR_BYTES + 2 + LABEL_BYTES);
        usable.mpls_etype = 1'b1;
        usable.label_outer = 1'b1;
        usable.sectag = ctx.rx_dir;
      end
      FMT_MPLS_TWO: begin
        tag_ok = mpls_seen;
        // Whole two-label header stays clear
        clear_len = 6'(ADDR_BYTES + 2 + 2 * LABEL_BYTES);
        usable.mpls_etype = 1'b1;
        usable.label_outer = 1'b1;
        usable.label_inner = 1'b1;
        usable.sectag = ctx.rx_dir;
      end
      default: begin
        tag_ok = 1'b0;
      end
    endcase
    // Any byte offset 0..127 is legal, the 7-bit field covers all
    ofs_ok = (ctx.conf_ofs >= CONF_OFS_MIN) ||
             (ctx.conf_ofs == CONF_OFS_NONE);
    // Encryption starts after SecTAG plus the offset
    enc_start = 8'(clear_len) + 8'(SECTAG_BYTES) + 8'(ctx.conf_ofs);
    key_bytes = ctx.key_256 ? 5'h1F : 5'h0F;
    next_result.usable = usable & ctx.sel;
    next_result.clear_len = clear_len;
    next_result.sectag_pos = clear_len;
    next_result.auth_start = clear_len;
    next_result.enc_start = enc_start;
    next_result.key_bytes = key_bytes;
    next_result.ofs_ok = ofs_ok;
    next_result.bypass_tag_ok = tag_ok;
    next_result_valid = ctx_valid;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      result <= '0;
      result_valid <= 1'b0;
    end else begin
      result <= next_result;
      result_valid <= next_result_valid;
    end
  end

  // Expansion buffer between system and line MACs
  logic fifo_out_valid, fifo_pop;
  beat_t fifo_out;
  logic [$clog2(FIFO_DEPTH):0] fill;
  logic in_ready;
  logic sys_push;
  logic next_line_valid;
  beat_t next_line_beat;

  beat_fifo #(
    .WIDTH(BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) pause_expansion_buffer (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(sys_push),
    .in_ready(in_ready),
    .in_data(sys_beat),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out),
    .level(fill)
  );

  // Only a beat the source saw taken may enter, else a held beat repeats
  assign sys_push = sys_valid && sys_ready;

  // Output register slot refills when empty or being consumed
  assign fifo_pop = fifo_out_valid && (!line_valid || line_ready);

  always_comb begin
    next_line_valid = line_valid;
    next_line_beat = line_beat;
    if (fifo_pop) begin
      next_line_valid = 1'b1;
      next_line_beat = fifo_out;
    end else if (line_ready) begin
      next_line_valid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      line_valid <= 1'b0;
      line_beat <= '0;
    end else begin
      line_valid <= next_line_valid;
      line_beat <= next_line_beat;
    end
  end

  // Pause with hysteresis so the request does not chatter per beat
  typedef enum logic [1:0] {
    FLOW_RUN = 2'b01,
    FLOW_PAUSE = 2'b10
  } flow_state_t;
  flow_state_t flow, next_flow;
  logic next_pause_req;
  logic [15:0] next_pause_quanta;
  logic next_sys_ready;

  always_comb begin
    next_flow = flow;
    unique case (flow)
      FLOW_RUN: begin
        if (fill >= 3'(PAUSE_HIGH)) begin
          next_flow = FLOW_PAUSE;
        end
      end
      FLOW_PAUSE: begin
        if (fill <= 3'(PAUSE_LOW)) begin
          next_flow = FLOW_RUN;
        end
      end
      default: begin
        next_flow = FLOW_RUN;
      end
    endcase
    next_pause_req = (next_flow == FLOW_PAUSE);
    next_pause_quanta = next_pause_req ? PAUSE_QUANTA : PAUSE_RELEASE;
    // Registered ready lags one beat; the high mark leaves room for it
    next_sys_ready = (fill < 3'(FIFO_DEPTH - 1)) ||
                     (fill == 3'(FIFO_DEPTH - 1) && fifo_pop);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flow <= FLOW_RUN;
      pause_req <= 1'b0;
      pause_quanta <= PAUSE_RELEASE;
      sys_ready <= 1'b0;
    end else begin
      flow <= next_flow;
      pause_req <= next_pause_req;
      pause_quanta <= next_pause_quanta;
      sys_ready <= next_sys_ready;
    end
  end

  // Checks
  a_rx_no_etype: assert property (
    @(posedge mclk) disable iff (!rstn)
    ctx_valid && ctx.rx_dir |=> !result.usable.etype)
    else $error("receive result exposes encrypted ethertype");
  a_std_rx_fields: assert property (
    @(posedge mclk) disable iff (!rstn)
    ctx_valid && ctx.rx_dir && ctx.fmt == FMT_STANDARD |=>
    !result.usable.tpid_outer && !result.usable.vid_inner)
    else $error("standard receive exposes tags");
  a_std_tx_tags: assert property (
    @(posedge mclk) disable iff (!rstn)
    ctx_valid && !ctx.rx_dir && ctx.fmt == FMT_STANDARD &&
    tag_count == 2'h2 && ctx.sel.vid_inner |=> result.usable.vid_inner)
    else $error("standard transmit drops inner vid");
  a_one_tag_len: assert property (
    @(posedge mclk) disable iff (!rstn)
    ctx_valid && ctx.fmt == FMT_ONE_TAG_BYPASS |=>
    result.sectag_pos == 6'h10 && (!$past(ctx.rx_dir) ||
    !result.usable.vid_inner))
    else $error("one-tag bypass layout wrong");
  a_two_tag_len: assert property (
    @(posedge mclk) disable iff (!rstn)
    ctx_valid && ctx.fmt == FMT_TWO_TAG_BYPASS |=>
    result.auth_start == 6'h14)
    else $error("two-tag bypass clear length wrong");
  a_mpls_len: assert property (
    @(posedge mclk) disable iff (!rstn)
    ctx_valid && ctx.fmt == FMT_MPLS_TWO |=>
    result.sectag_pos == 6'h16)
    else $error("two-label clear length wrong");
  a_sel_mask: assert property (
    @(posedge mclk) disable iff (!rstn)
    ctx_valid |=> (result.usable & ~$past(ctx.sel)) == '0)
    else $error("field used without selection");
  a_key_len: assert property (
    @(posedge mclk) disable iff (!rstn)
    ctx_valid |=> result.key_bytes ==
    ($past(ctx.key_256) ? 5'h1F : 5'h0F))
    else $error("key length mismatch");
  a_pause_high: assert property (
    @(posedge mclk) disable iff (!rstn)
    fill >= 3'(PAUSE_HIGH) |=> pause_req)
    else $error("no pause at high fill");
  a_no_loss: assert property (
    @(posedge mclk) disable iff (!rstn)
    sys_push |-> in_ready)
    else $error("beat accepted with no buffer room");
  a_enc_after_tag: assert property (
    @(posedge mclk) disable iff (!rstn)
    result_valid |-> result.enc_start >=
    8'(result.sectag_pos) + 8'(SECTAG_BYTES))
    else $error("encryption starts before SecTAG end");

  c_pause_seen: cover property (@(posedge mclk) disable iff (!rstn)
    $rose(pause_req));
  c_pause_release: cover property (@(posedge mclk) disable iff (!rstn)
    $fell(pause_req));
  c_mpls_rx: cover property (@(posedge mclk) disable iff (!rstn)
    ctx_valid && ctx.rx_dir && ctx.fmt == FMT_MPLS_ONE);
  c_buffer_full: cover property (@(posedge mclk) disable iff (!rstn)
    fill == 3'(FIFO_DEPTH));
endmodule

// ==== shared/frame_class_pkg.sv ====
// Shared constants and types for the frame-format classifier
package frame_class_pkg;

  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int HDR_BYTES = 48;
  localparam int ADDR_BYTES = 12;
  localparam int TAG_BYTES = 4;
  localparam int LABEL_BYTES = 4;
  localparam int SECTAG_BYTES = 16;
  localparam logic [15:0] TPID_CTAG = 16'h8100;
  localparam logic [15:0] TPID_STAG = 16'h88A8;
  localparam logic [15:0] ETYPE_MPLS = 16'h8847;
  localparam logic [6:0] CONF_OFS_MIN = 7'h01;
  localparam logic [6:0] CONF_OFS_MAX = 7'h7F;
  localparam logic [6:0] CONF_OFS_NONE = 7'h00;
  localparam logic [6:0] CONF_OFS_30 = 7'h1E;
  localparam logic [6:0] CONF_OFS_50 = 7'h32;
  localparam logic [2:0] PAUSE_HIGH = 3'h3;
  localparam logic [2:0] PAUSE_LOW = 3'h1;
  localparam logic [15:0] PAUSE_QUANTA = 16'hFFFF;
  localparam logic [15:0] PAUSE_RELEASE = 16'h0000;

  typedef enum logic [2:0] {
    FMT_STANDARD = 3'h0,
    FMT_ONE_TAG_BYPASS = 3'h1,
    FMT_TWO_TAG_BYPASS = 3'h2,
    FMT_MPLS_ONE = 3'h3,
    FMT_MPLS_TWO = 3'h4
  } frame_fmt_t;

  typedef struct packed {
    logic dest_addr;
    logic src_addr;
    logic tpid_outer;
    logic vid_outer;
    logic tpid_inner;
    logic vid_inner;
    logic etype;
    logic mpls_etype;
    logic label_outer;
    logic label_inner;
    logic sectag;
  } field_set_t;

  typedef struct packed {
    frame_fmt_t fmt;
    logic rx_dir;
    logic key_256;
    logic [6:0] conf_ofs;
    field_set_t sel;
  } sa_ctx_t;

  typedef struct packed {
    field_set_t usable;
    logic [5:0] clear_len;
    logic [5:0] sectag_pos;
    logic [5:0] auth_start;
    logic [7:0] enc_start;
    logic [4:0] key_bytes;
    logic ofs_ok;
    logic bypass_tag_ok;
  } class_result_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic last;
  } beat_t;

  localparam int BEAT_W = DATA_W + 1;

endpackage

// ==== logic/beat_fifo.sv ====
// Small valid/ready FIFO holding egress beats during frame expansion
`timescale 1ns/1ps
module beat_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign level = count;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage has no reset; only the count slots from rd_ptr onward are ever read out
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ==== test/line_mac_model.sv ====
// Line-side MAC model that takes egress beats and stalls on request
`timescale 1ns/1ps
module line_mac_model #(
  parameter logic [15:0] SEED = 16'hACE1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Behaviour control
  input wire logic stall,
  // Sink handshake
  input wire logic line_valid,
  output logic line_ready
);
  logic [15:0] lfsr;
  // Random ready keeps beats waiting in the output register over edges
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lfsr <= SEED;
      line_ready <= 1'b0;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      line_ready <= !stall && (lfsr[0] || !line_valid);
    end
  end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the frame-format classifier and pause buffer
`timescale 1ns/1ps
module testbench
  import frame_class_pkg::*;
;
  logic mclk, rstn, ctx_valid, mpls_seen, sys_valid, sys_ready;
  logic result_valid, line_valid, line_ready, pause_req, stall;
  logic [1:0] tag_count;
  logic [15:0] pause_quanta;
  logic [31:0] rnd;
  sa_ctx_t ctx;
  class_result_t result;
  beat_t sys_beat, line_beat;
  int error_cnt, n_compared;
  class_result_t cq[$];
  beat_t sq[$];

  frame_format_classifier frame_format_classifier_inst (
    .mclk(mclk), .rstn(rstn), .ctx(ctx), .tag_count(tag_count),
    .mpls_seen(mpls_seen), .ctx_valid(ctx_valid), .result(result),
    .result_valid(result_valid), .sys_valid(sys_valid),
    .sys_ready(sys_ready), .sys_beat(sys_beat), .line_valid(line_valid),
    .line_ready(line_ready), .line_beat(line_beat),
    .pause_req(pause_req), .pause_quanta(pause_quanta)
  );
  line_mac_model line_mac_model_inst (
    .mclk(mclk), .rstn(rstn), .stall(stall), .line_valid(line_valid),
    .line_ready(line_ready)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Reference classification written from the frame-format tables
  function automatic class_result_t exp_res(sa_ctx_t c, logic [1:0] tc,
                                            logic ms);
    class_result_t r;
    field_set_t u;
    r = '0;
    u = '0;
    u.dest_addr = 1'b1;
    u.src_addr = 1'b1;
    if (c.fmt == FMT_MPLS_ONE || c.fmt == FMT_MPLS_TWO) begin
      u.mpls_etype = 1'b1;
      u.label_outer = 1'b1;
      u.label_inner = (c.fmt == FMT_MPLS_TWO);
      u.sectag = c.rx_dir;
      r.clear_len = (c.fmt == FMT_MPLS_TWO) ? 6'h16 : 6'h12;
    end else begin
      if (c.rx_dir) begin
        u.sectag = 1'b1;
        u.tpid_outer = (c.fmt != FMT_STANDARD);
        u.vid_outer = (c.fmt != FMT_STANDARD);
        u.tpid_inner = (c.fmt == FMT_TWO_TAG_BYPASS);
        u.vid_inner = (c.fmt == FMT_TWO_TAG_BYPASS);
      end else begin
        u.tpid_outer = (tc >= 2'h1);
        u.vid_outer = (tc >= 2'h1);
        u.tpid_inner = (tc == 2'h2);
        u.vid_inner = (tc == 2'h2);
        u.etype = 1'b1;
      end
      r.clear_len = 6'h0C + 6'(4 * c.fmt);
    end
    r.usable = u & c.sel;
    r.sectag_pos = r.clear_len;
    r.auth_start = r.clear_len;
    r.enc_start = {2'h0, r.clear_len} + 8'h10 + {1'h0, c.conf_ofs};
    r.key_bytes = c.key_256 ? 5'h1F : 5'h0F;
    r.ofs_ok = 1'b1;
    // An MPLS mode on a frame without the MPLS type does not fit
    r.bypass_tag_ok = (c.fmt == FMT_MPLS_ONE || c.fmt == FMT_MPLS_TWO) ?
                      ms : 1'b1;
    return r;
  endfunction

  task automatic chk(input string name, input logic [63:0] exp,
                     input logic [63:0] got);
    n_compared++;
    if (exp !== got) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("Compared %0d values, %0d mismatches", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Beat source; a bubble follows each beat so valid is never set twice
  task automatic send(input beat_t b, input bit honour);
    @(negedge mclk);
    for (int k = 0; k < 200 && honour && pause_req !== 1'b0; k++) begin
      @(negedge mclk);
    end
    @(posedge mclk);
    sys_valid <= 1'b1;
    sys_beat <= b;
    for (int k = 0; k < 200; k++) begin
      @(negedge mclk);
      if (sys_ready === 1'b1) break;
      @(posedge mclk);
    end
    sq.push_back(b);
    @(posedge mclk);
    sys_valid <= 1'b0;
  endtask

  task automatic wait_drain();
    for (int k = 0; k < 400 && sq.size() != 0; k++) @(posedge mclk);
    chk("beats_left", 64'h0, sq.size());
  endtask

  always @(negedge mclk) begin
    if (result_valid === 1'b1) begin
      if (cq.size() == 0) chk("result_valid", 64'h0, result_valid);
      else chk("result", cq.pop_front(), result);
    end
  end

  always @(posedge mclk) begin
    if (rstn === 1'b1 && line_valid === 1'b1 && line_ready === 1'b1) begin
      if (sq.size() == 0) chk("line_valid", 64'h0, line_valid);
      else chk("line_beat", sq.pop_front(), line_beat);
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end

  initial begin
    sa_ctx_t c;
    logic [1:0] tc;
    logic ms;
    rstn = 1'b0;
    ctx = '0;
    tag_count = 2'h0;
    mpls_seen = 1'b0;
    ctx_valid = 1'b0;
    sys_valid = 1'b0;
    sys_beat = '0;
    stall = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    rnd = 32'h00011089;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk("reset_outputs", 64'h0,
        {sys_ready, line_valid, pause_req, result_valid, pause_quanta});
    @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("sys_ready", 64'h1, sys_ready);
    // Back-to-back classification, every format in both directions
    for (int i = 0; i < 150; i++) begin
      rnd = lfsr_next(rnd);
      c.fmt = frame_fmt_t'(3'((i < 10) ? i % 5 : rnd[7:0] % 5));
      c.rx_dir = (i < 10) ? (i >= 5) : rnd[11];
      c.key_256 = rnd[10];
      c.conf_ofs = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : rnd[9:3];
      c.sel = (i < 10) ? 11'h7FF : rnd[22:12];
      case (c.fmt)
        FMT_STANDARD: tc = 2'(rnd[24:23] % 3);
        FMT_ONE_TAG_BYPASS: tc = rnd[23] ? 2'h2 : 2'h1;
        FMT_TWO_TAG_BYPASS: tc = 2'h2;
        default: tc = 2'h0;
      endcase
      // Now and then the frame contradicts its MPLS mode
      ms = (c.fmt == FMT_MPLS_ONE || c.fmt == FMT_MPLS_TWO) ^
           (i >= 10 && rnd[26:25] == 2'h3);
      @(posedge mclk);
      ctx <= c;
      tag_count <= tc;
      mpls_seen <= ms;
      ctx_valid <= 1'b1;
      cq.push_back(exp_res(c, tc, ms));
    end
    @(posedge mclk);
    ctx_valid <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("results_left", 64'h0, cq.size());
    // Random stream with a randomly stalling sink
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr_next(rnd);
      send('{data: rnd[7:0], last: (i % 8 == 7)}, 1'b1);
    end
    wait_drain();
    // Stalled sink: fill until pause and refusal, then drain
    @(posedge mclk);
    stall <= 1'b1;
    fork
      begin
        repeat (40) @(posedge mclk);
        stall <= 1'b0;
      end
    join_none
    for (int i = 0; i < 4; i++) begin
      send('{data: 8'hA0 + 8'(i), last: 1'b0}, 1'b0);
    end
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("pause_on", 64'h3FFFE,
        {pause_req, pause_quanta, sys_ready});
    for (int i = 4; i < 6; i++) begin
      send('{data: 8'hA0 + 8'(i), last: 1'b1}, 1'b0);
    end
    wait_drain();
    repeat (2) @(negedge mclk);
    chk("pause_off", 64'h0, {pause_req, pause_quanta});
    complete_run();
  end
endmodule
